// ### hw/spmc_core.v
// Byte-wide serial master/slave controller with CPU register port
`timescale 1ns/1ps
`include "spmc_regs.vh"
// Notes on behaviour
// - Slave with phase 0 drives its MSB as soon as select falls.
// - Phase 0 slave: load data before select falls again.
// - Phase 1 slave: first clock edge starts a byte; select may stay low.
// - Master with select enabled sets mode fault when select driven low.
// - Mode fault clears interface enable and master select at once.
// - Mode fault clears after status read then control write.
// - Data write during transfer sets collision, is discarded, transfer continues.
// - Write collision never requests an interrupt.
// - Collision clears after status read then idle data write.
// - Transfer done and mode fault are ORed into one request.
// - Done flag set after eight bits; cleared by status then data access.
// - Interrupt reaches core only with own and global enables set.
// - Master select at control bit 4 makes the controller master.
// - Slave when master bit clear and a byte is loaded.
// - Rate bits: high at bit 7, low two at bits 1-0.
// - Bit 6 enables the interface; disabled clock output sits high.
// - Bit 5 disables select input; no effect in phase 0 slave.
// - Bit 2 selects sample edge: set samples on return to idle.
// - Control register resets to 0x14.
// - Bit 3 sets master clock idle level.
// - Rate codes 0-6 divide by 2..128; code 7 divides by 2, the same as code 0.
// - Master data write starts transfer, MSB first, receive shifts in.
module spmc_core (
    // Clock and reset
    input wire clk,
    input wire rst,
    // CPU register port
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // Interrupt enables and request
    input wire serial_irq_enable,
    input wire global_irq_enable,
    output reg irq,
    // Serial pins
    input wire sck_in,
    output reg sck_out,
    output reg sck_oe,
    input wire mosi_in,
    output reg mosi_out,
    output reg mosi_oe,
    input wire miso_in,
    output reg miso_out,
    output reg miso_oe,
    input wire ss_n_in,
    // Received byte stream
    output reg rx_valid,
    input wire rx_ready,
    output reg [7:0] rx_data
);
    localparam ST_IDLE = 2'h0;
    localparam ST_LEAD = 2'h1;
    localparam ST_TRAIL = 2'h2;

    // Rate code to half-period minus one; divide by 1 toggles each edge
    function [6:0] half_period;
        input [2:0] code;
        begin
            if (code == `SPMC_RATE_DIV1) begin
                half_period = 7'h00;
            end else begin
                half_period = (7'h01 << code) - 7'h01;
            end
        end
    endfunction

    function is_addr;
        input [7:0] a;
        input [7:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    reg [7:0] serial_control_reg;
    reg [7:0] shift_reg;
    reg [7:0] serial_data_reg;
    reg transfer_done_flag;
    reg write_collision_flag;
    reg mode_fault_flag;
    reg stat_read_reg;
    reg loaded_reg;
    reg [1:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [6:0] div_reg;
    reg sample_reg;
    reg [2:0] sck_sync_reg;
    reg [2:0] ss_sync_reg;
    reg [1:0] mosi_sync_reg;
    reg [1:0] miso_sync_reg;

    wire on = serial_control_reg[`SPMC_BIT_ON];
    wire master = serial_control_reg[`SPMC_BIT_MASTER];
    wire ss_off = serial_control_reg[`SPMC_BIT_SS_OFF];
    wire clock_idle_polarity = serial_control_reg[`SPMC_BIT_CLOCK_IDLE_POLARITY];
    wire clock_sample_phase = serial_control_reg[`SPMC_BIT_CLOCK_SAMPLE_PHASE];
    wire [2:0] rate = {serial_control_reg[`SPMC_BIT_RATE_HI], serial_control_reg[1:0]};
    wire ss_n = ss_sync_reg[1];
    wire sck_s = sck_sync_reg[1];
    wire sck_rise = sck_sync_reg[1] && !sck_sync_reg[2];
    wire sck_fall = !sck_sync_reg[1] && sck_sync_reg[2];
    wire ss_fall = !ss_sync_reg[1] && ss_sync_reg[2];
    wire busy = (state_reg != ST_IDLE);
    wire wr_ctrl = reg_wr && is_addr(reg_addr, `SPMC_ADDR_CTRL);
    wire wr_data = reg_wr && is_addr(reg_addr, `SPMC_ADDR_DATA);
    wire rd_stat = reg_rd && is_addr(reg_addr, `SPMC_ADDR_STAT);
    wire rd_data = reg_rd && is_addr(reg_addr, `SPMC_ADDR_DATA);
    // Select input honoured unless disabled; phase 0 slave always uses it
    wire ss_used = !ss_off || (!master && !clock_sample_phase);
    wire slave_sel = !ss_used || !ss_n;
    // Another master pulling select low while we master
    wire fault = on && master && !ss_off && !ss_n;
    // Slave edges in idle-relative terms: leading leaves idle
    wire s_lead = clock_idle_polarity ? sck_fall : sck_rise;
    wire s_trail = clock_idle_polarity ? sck_rise : sck_fall;
    wire s_sample = clock_sample_phase ? s_trail : s_lead;
    wire s_shift = clock_sample_phase ? s_lead : s_trail;
    wire m_tick = (div_reg == 7'h00);
    wire byte_end = (bit_cnt_reg == `SPMC_BITS_PER_BYTE);
    wire fifo_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    reg done_d_reg;
    wire transfer_done_pulse = transfer_done_flag && !done_d_reg;

    always @(posedge clk) begin
        if (rst) begin
            sck_sync_reg <= 3'h7;
            ss_sync_reg <= 3'h7;
            mosi_sync_reg <= 2'h0;
            miso_sync_reg <= 2'h0;
        end else begin
            sck_sync_reg <= {sck_sync_reg[1:0], sck_in};
            ss_sync_reg <= {ss_sync_reg[1:0], ss_n_in};
            mosi_sync_reg <= {mosi_sync_reg[0], mosi_in};
            miso_sync_reg <= {miso_sync_reg[0], miso_in};
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            // Reset to master, phase 1, disabled
            serial_control_reg <= `SPMC_CTRL_RESET;
            shift_reg <= 8'h00;
            serial_data_reg <= 8'h00;
            transfer_done_flag <= 1'b0;
            write_collision_flag <= 1'b0;
            mode_fault_flag <= 1'b0;
            stat_read_reg <= 1'b0;
            loaded_reg <= 1'b0;
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            div_reg <= 7'h00;
            sample_reg <= 1'b0;
            sck_out <= 1'b1;
            sck_oe <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe <= 1'b0;
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
            irq <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            if (rd_stat) begin
                stat_read_reg <= 1'b1;
            end else if (wr_ctrl || wr_data || rd_data) begin
                stat_read_reg <= 1'b0;
            end
            // Status read then control write clears fault
            if (wr_ctrl && stat_read_reg) begin
                mode_fault_flag <= 1'b0;
            end
            if (wr_ctrl) begin
                serial_control_reg <= reg_wdata;
            end
            if (fault) begin
                mode_fault_flag <= 1'b1;
                serial_control_reg[`SPMC_BIT_ON] <= 1'b0;
                serial_control_reg[`SPMC_BIT_MASTER] <= 1'b0;
            end
            // Done clears on status then data access
            if ((rd_data || wr_data) && stat_read_reg) begin
                transfer_done_flag <= 1'b0;
            end
            if (wr_data) begin
                if (busy) begin
                    write_collision_flag <= 1'b1;
                end else begin
                    // Idle write after status read clears collision
                    if (stat_read_reg) begin
                        write_collision_flag <= 1'b0;
                    end
                    shift_reg <= reg_wdata;
                    loaded_reg <= 1'b1;
                end
            end
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                if (is_addr(reg_addr, `SPMC_ADDR_CTRL)) begin
                    reg_rdata <= serial_control_reg;
                end else if (is_addr(reg_addr, `SPMC_ADDR_STAT)) begin
                    reg_rdata <= {transfer_done_flag, write_collision_flag, 1'b0, mode_fault_flag, 4'h0};
                end else if (is_addr(reg_addr, `SPMC_ADDR_DATA)) begin
                    reg_rdata <= serial_data_reg;
                end
            end

            sck_oe <= on && master;
            mosi_oe <= on && master;
            miso_oe <= on && !master && slave_sel;
            if (!on || !master) begin
                sck_out <= on ? clock_idle_polarity : 1'b1;
            end

            if (!on) begin
                state_reg <= ST_IDLE;
                bit_cnt_reg <= 4'h0;
            end else if (master) begin
                case (state_reg)
                    ST_IDLE: begin
                        sck_out <= clock_idle_polarity;
                        // Idle data write starts a transfer
                        if (wr_data && fifo_ready) begin
                            state_reg <= ST_LEAD;
                            div_reg <= half_period(rate);
                            bit_cnt_reg <= 4'h0;
                            mosi_out <= reg_wdata[7];
                        end
                    end
                    ST_LEAD: begin
                        if (m_tick) begin
                            div_reg <= half_period(rate);
                            sck_out <= !clock_idle_polarity;
                            // Phase clear samples on leaving idle
                            if (!clock_sample_phase) begin
                                sample_reg <= miso_sync_reg[1];
                            end else begin
                                mosi_out <= shift_reg[7];
                            end
                            state_reg <= ST_TRAIL;
                        end else begin
                            div_reg <= div_reg - 7'h01;
                        end
                    end
                    ST_TRAIL: begin
                        if (m_tick) begin
                            div_reg <= half_period(rate);
                            sck_out <= clock_idle_polarity;
                            if (!clock_sample_phase) begin
                                shift_reg <= {shift_reg[6:0], sample_reg};
                                mosi_out <= shift_reg[6];
                            end else begin
                                shift_reg <= {shift_reg[6:0], miso_sync_reg[1]};
                            end
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (bit_cnt_reg == `SPMC_BITS_PER_BYTE - 4'h1) begin
                                state_reg <= ST_IDLE;
                                transfer_done_flag <= 1'b1;
                                loaded_reg <= 1'b0;
                                serial_data_reg <= clock_sample_phase ? {shift_reg[6:0], miso_sync_reg[1]}
                                                        : {shift_reg[6:0], sample_reg};
                            end else begin
                                state_reg <= ST_LEAD;
                            end
                        end else begin
                            div_reg <= div_reg - 7'h01;
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end else begin
                // Slave works only with a byte loaded
                if (!slave_sel || !loaded_reg) begin
                    // Phase 0 idles when deselected or unloaded; restart needs only an idle clock, select may stay low
                    if (!clock_sample_phase) begin
                        state_reg <= ST_IDLE;
                        bit_cnt_reg <= 4'h0;
                    end
                end else begin
                    // Phase 0: MSB out as soon as selected
                    if (!clock_sample_phase && state_reg == ST_IDLE) begin
                        miso_out <= shift_reg[7];
                        if (ss_fall || !sck_s == !clock_idle_polarity) begin
                            state_reg <= ST_LEAD;
                        end
                    end
                    // Phase 1: first edge starts the byte
                    if (clock_sample_phase && state_reg == ST_IDLE && s_lead) begin
                        state_reg <= ST_LEAD;
                        miso_out <= shift_reg[7];
                    end else if (busy || (!clock_sample_phase && ss_fall)) begin
                        if (s_sample) begin
                            sample_reg <= mosi_sync_reg[1];
                        end
                        if (s_shift && !(clock_sample_phase && state_reg == ST_IDLE)) begin
                            shift_reg <= {shift_reg[6:0], sample_reg};
                            miso_out <= shift_reg[6];
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                    if (byte_end) begin
                        state_reg <= ST_IDLE;
                        bit_cnt_reg <= 4'h0;
                        transfer_done_flag <= 1'b1;
                        loaded_reg <= 1'b0;
                        serial_data_reg <= shift_reg;
                    end
                end
            end
            irq <= (transfer_done_flag || mode_fault_flag) && serial_irq_enable && global_irq_enable;
        end
    end

    // Received bytes queued for a downstream consumer; a full queue blocks new master starts
    spmc_fifo #(
        .WIDTH(8),
        .DEPTH(`SPMC_FIFO_DEPTH),
        .AW(`SPMC_FIFO_AW)
    ) u_rx_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(transfer_done_pulse),
        .in_ready(fifo_ready),
        .in_data(serial_data_reg),
        .out_valid(fifo_out_valid),
        .out_ready(rx_ready || !rx_valid),
        .out_data(fifo_out_data)
    );

    always @(posedge clk) begin
        if (rst) begin
            done_d_reg <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
        end else begin
            done_d_reg <= transfer_done_flag;
            if (rx_ready || !rx_valid) begin
                rx_valid <= fifo_out_valid;
                rx_data <= fifo_out_data;
            end
        end
    end
endmodule

// ### inc/spmc_regs.vh
// Register addresses, field positions, reset values and rate codes of the serial controller
`ifndef SPMC_REGS_VH
`define SPMC_REGS_VH
`define SPMC_ADDR_CTRL 8'hc3
`define SPMC_ADDR_STAT 8'hc4
`define SPMC_ADDR_DATA 8'hc5
`define SPMC_CTRL_RESET 8'h14
`define SPMC_BIT_RATE_HI 7
`define SPMC_BIT_ON 6
`define SPMC_BIT_SS_OFF 5
`define SPMC_BIT_MASTER 4
`define SPMC_BIT_CLOCK_IDLE_POLARITY 3
`define SPMC_BIT_CLOCK_SAMPLE_PHASE 2
`define SPMC_BIT_DONE 7
`define SPMC_BIT_WRITE_COLLISION_FLAG 6
`define SPMC_BIT_MODE_FAULT_FLAG 4
`define SPMC_RATE_DIV1 3'h7
`define SPMC_BITS_PER_BYTE 4'h8
`define SPMC_FIFO_DEPTH 32
`define SPMC_FIFO_AW 5
`endif

// ### hw/spmc_fifo.v
// Synchronous FIFO with registered read data and valid/ready on both sides
`timescale 1ns/1ps
`include "spmc_regs.vh"
module spmc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = `SPMC_FIFO_DEPTH,
    parameter AW = `SPMC_FIFO_AW
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output reg out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr_reg;
    reg [AW:0] rd_ptr_reg;
    wire [AW:0] count = wr_ptr_reg - rd_ptr_reg;
    wire full = (count == DEPTH);
    wire empty = (count == {(AW+1){1'b0}});
    // Output stage refills when empty or being consumed
    wire load = !empty && (!out_valid || out_ready);
    assign in_ready = !full;

    always @(posedge clk) begin
        if (in_valid && !full) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
        if (rst) begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end else begin
            if (in_valid && !full) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (load) begin
                out_data <= mem[rd_ptr_reg[AW-1:0]];
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule

// ### testbench/spmc_properties.sv
// Concurrent checks on the serial controller's pins
`timescale 1ns/1ps
module spmc_properties (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register strobe and interrupt
    input wire reg_wr,
    input wire serial_irq_enable,
    input wire global_irq_enable,
    input wire irq,
    // Serial pins and received stream
    input wire sck_out,
    input wire sck_oe,
    input wire mosi_oe,
    input wire miso_oe,
    input wire rx_valid,
    input wire rx_ready,
    input wire [7:0] rx_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [4:0] edge_cnt;
    logic sck_d;
    // Clock edges since the last register write; saturates so a runaway shows
    always @(posedge clk) begin
        sck_d <= sck_out;
        if (rst || reg_wr)
            edge_cnt <= 5'h00;
        else if (sck_oe && sck_out != sck_d && edge_cnt != 5'h1f)
            edge_cnt <= edge_cnt + 5'h01;
    end
    property p_reset_idle;
        $fell(rst) |-> sck_out && !sck_oe;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("serial clock not idle high after reset");
    property p_irq_own;
        (!serial_irq_enable) [*2] |-> !irq;
    endproperty
    a_irq_own: assert property (p_irq_own) else $error("irq while own enable low");
    property p_irq_global;
        (!global_irq_enable) [*2] |-> !irq;
    endproperty
    a_irq_global: assert property (p_irq_global) else $error("irq while global enable low");
    property p_irq_rise;
        $rose(irq) |-> $past(serial_irq_enable && global_irq_enable);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without both enables");
    property p_master_pins;
        mosi_oe |-> sck_oe;
    endproperty
    a_master_pins: assert property (p_master_pins) else $error("data out driven without clock");
    property p_slave_pin;
        miso_oe |-> !sck_oe;
    endproperty
    a_slave_pin: assert property (p_slave_pin) else $error("slave output while driving clock");
    property p_byte_edges;
        edge_cnt <= 5'h10;
    endproperty
    a_byte_edges: assert property (p_byte_edges) else $error("more than eight clock cycles per byte");
    property p_rx_hold;
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("received byte dropped while stalled");
endmodule
bind spmc_core spmc_properties u_chk (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .serial_irq_enable(serial_irq_enable), .global_irq_enable(global_irq_enable), .irq(irq),
    .sck_out(sck_out), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));

// ### testbench/spmc_slave_model.sv
// Behavioural serial slave answering the controller in master mode
`timescale 1ns/1ps
module spmc_slave_model (
    // Select and format
    input wire sel_n,
    input wire clock_idle_polarity,
    input wire clock_sample_phase,
    input wire [7:0] tx_byte,
    // Serial lines
    input wire sck,
    input wire mosi,
    output logic miso,
    // Byte collected from the master
    output logic [7:0] rx_byte
);
    logic [7:0] sh;
    initial miso = 1'b0;
    always @(negedge sel_n) begin
        sh = tx_byte;
        // phase 0 shows MSB at select
        if (!clock_sample_phase)
            miso = tx_byte[7];
    end
    // Released line shows the inverse, so a stale bit never passes
    always @(posedge sel_n) miso = ~miso;
    always @(sck) begin
        if (sel_n === 1'b0) begin
            if ((sck != clock_idle_polarity) != clock_sample_phase)
                rx_byte = {rx_byte[6:0], mosi};
            else if (clock_sample_phase) begin
                miso = sh[7];
                sh = {sh[6:0], 1'b0};
            end else begin
                sh = {sh[6:0], 1'b0};
                miso = sh[7];
            end
        end
    end
endmodule

// ### testbench/tb.sv
// Register-level tests of the serial controller against a slave model
`timescale 1ns/1ps
`include "spmc_regs.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb;
    logic clk, rst, reg_wr, reg_rd, sie, gie, tb_sck, tb_mosi, ss_n, m_sel_n, rx_ready;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_data, m_tx, m_rx, d, st, ctrl;
    logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq, rx_valid, m_miso;
    logic sck_d1;
    wire sck_w = sck_oe ? sck_out : tb_sck;
    wire mosi_w = mosi_oe ? mosi_out : tb_mosi;
    wire miso_w = miso_oe ? miso_out : m_miso;
    int n_fail = 0;
    int checked = 0;
    spmc_core DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .serial_irq_enable(sie), .global_irq_enable(gie),
        .irq(irq), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w),
        .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
        .miso_oe(miso_oe), .ss_n_in(ss_n), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
    spmc_slave_model u_slave (.sel_n(m_sel_n), .clock_idle_polarity(ctrl[3]), .clock_sample_phase(ctrl[2]), .tx_byte(m_tx),
        .sck(sck_w), .mosi(mosi_w), .miso(m_miso), .rx_byte(m_rx));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input [7:0] a, input [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic set_ctrl(input [7:0] v);
        ctrl = v;
        wr(`SPMC_ADDR_CTRL, v);
        repeat (3) @(posedge clk);
    endtask
    // One master byte; optional colliding write in mid-transfer
    task automatic xfer(input [7:0] tx, input [7:0] mtx, input bit coll);
        int n;
        int h;
        m_tx = mtx;
        m_sel_n <= 1'b0;
        wr(`SPMC_ADDR_DATA, tx);
        n = 0;
        #1;
        while (sck_out === sck_d1 && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        h = 0;
        do begin
            @(posedge clk);
            #1 h++;
        end while (sck_out === sck_d1 && h < 300);
        `CHK(h, 1 << {ctrl[7], ctrl[1:0]})
        if (coll)
            wr(`SPMC_ADDR_DATA, ~tx);
        st = 8'h00;
        n = 0;
        while (st[`SPMC_BIT_DONE] !== 1'b1 && n < 400) begin
            rd(`SPMC_ADDR_STAT);
            st = d;
            n++;
        end
        `CHK(st[`SPMC_BIT_DONE], 1'b1)
        `CHK(st[`SPMC_BIT_WRITE_COLLISION_FLAG], coll)
        `CHK(irq, sie & gie)
        `CHK(m_rx, tx)
        rd(`SPMC_ADDR_DATA);
        `CHK(d, mtx)
        rd(`SPMC_ADDR_STAT);
        `CHK(d[`SPMC_BIT_DONE], 1'b0)
        if (n >= 400)
            test_done();
        m_sel_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    always @(posedge clk) sck_d1 <= sck_out;
    initial begin
        {rst, reg_wr, reg_rd, sie, gie, tb_sck, tb_mosi, ss_n, m_sel_n, rx_ready} = 10'b1000000110;
        {reg_addr, reg_wdata, m_tx, ctrl} = 32'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(`SPMC_ADDR_CTRL);
        `CHK(d, `SPMC_CTRL_RESET)
        `CHK(sck_out, 1'b1)
        wr(8'h00, 8'hff);
        rd(`SPMC_ADDR_CTRL);
        `CHK(d, `SPMC_CTRL_RESET)
        $display("Test reset done");
        sie <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            gie <= m[0];
            set_ctrl({4'b0111, m[1:0], 2'b10});
            `CHK(sck_out, m[1])
            xfer(8'ha5 ^ m[7:0], 8'h3c + m[7:0], 1'b0);
        end
        $display("Test modes done");
        set_ctrl(8'h77);
        xfer(8'hc3, 8'h81, 1'b1);
        rd(`SPMC_ADDR_STAT);
        xfer(8'h5a, 8'he7, 1'b0);
        $display("Test collision done");
        // Received bytes were held back by a stalled consumer
        for (int j = 0; j < 6; j++) begin
            `CHK({rx_valid, rx_data}, {1'b1, j < 4 ? 8'h3c + j[7:0] : (j == 4 ? 8'h81 : 8'he7)})
            rx_ready <= 1'b1;
            @(posedge clk);
            rx_ready <= 1'b0;
            repeat (2) @(posedge clk);
        end
        $display("Test receive stream done");
        set_ctrl(8'h55);
        ss_n <= 1'b0;
        repeat (6) @(posedge clk);
        rd(`SPMC_ADDR_STAT);
        `CHK(d[`SPMC_BIT_MODE_FAULT_FLAG], 1'b1)
        `CHK(irq, 1'b1)
        rd(`SPMC_ADDR_CTRL);
        `CHK({d[`SPMC_BIT_ON], d[`SPMC_BIT_MASTER]}, 2'b00)
        rd(`SPMC_ADDR_DATA);
        ss_n <= 1'b1;
        wr(`SPMC_ADDR_CTRL, `SPMC_CTRL_RESET);
        rd(`SPMC_ADDR_STAT);
        `CHK(d[`SPMC_BIT_MODE_FAULT_FLAG], 1'b1)
        wr(`SPMC_ADDR_CTRL, `SPMC_CTRL_RESET);
        rd(`SPMC_ADDR_STAT);
        `CHK(d[`SPMC_BIT_MODE_FAULT_FLAG], 1'b0)
        $display("Test mode fault done");
        set_ctrl(8'h41);
        for (int k = 0; k < 2; k++) begin
            wr(`SPMC_ADDR_DATA, k[0] ? 8'h69 : 8'h96);
            ss_n <= 1'b0;
            repeat (5) @(posedge clk);
            `CHK({miso_oe, miso_out}, {1'b1, ~k[0]})
            ss_n <= 1'b1;
            repeat (5) @(posedge clk);
        end
        $display("Test slave select done");
        test_done();
    end
endmodule
